/* File: rtl/servo_seq_io_cfg.svh */
// Constants for the servo sequence I/O logic.
`ifndef SERVO_SEQ_IO_CFG_SVH
`define SERVO_SEQ_IO_CFG_SVH
// ----------------------------------------------------------------------
// Configuration digit values
// ----------------------------------------------------------------------
`define TLIM_ANALOG_SEL 4'h1
`define MODE_SPD_ASPD 4'h4
`define MODE_SPD_POS 4'h5
`define MODE_SPD_TRQ 4'h6
`define MODE_POS_ASPD 4'h7
`define MODE_POS_TRQ 4'h8
`define MODE_TRQ_ASPD 4'h9
`define MODE_ASPD_ZCLAMP 4'hA
`define MODE_POS_INHIBIT 4'hB
// ----------------------------------------------------------------------
// Rotation threshold, rpm
// ----------------------------------------------------------------------
`define ROT_THRESH_MAX 16'h0BB8
`define ROT_THRESH_DEFAULT 16'h0014
`endif

/* File: rtl/servo_seq_io_pkg.sv */
// Types for the servo sequence I/O logic.
package servo_seq_io_pkg;
    typedef enum logic [2:0] {
        CTRL_SPEED_CONTACT = 3'b000,
        CTRL_SPEED_ANALOG = 3'b001,
        CTRL_POSITION = 3'b010,
        CTRL_TORQUE = 3'b011,
        CTRL_ZERO_CLAMP = 3'b100,
        CTRL_POS_INHIBIT = 3'b101
    } ctrl_mode_t;

    typedef struct packed {
        logic fault_detected;
        logic servo_on_cmd;
        logic prep_done;
        logic main_power_on;
        logic encoder_index;
    } drive_state_t;
endpackage

/* File: rtl/servo_sequence_io_logic.sv */
// Sequence I/O logic: torque limit, mode switching, alarm, status outputs.
// Overview of operation
// - Analog torque limit is applied only in speed or position control.
// - The analog limit is unsigned; sign of the input does not matter.
// - One limit from the magnitude caps both forward and reverse torque.
// - The analog limit is used only when the function digit enables it.
// - Mode digit 4..B decodes into a pair of base and alternate modes.
// - For digits 4,5,6 both limit contacts high select the alternate mode.
// - Alarm output is low when normal and high on an abnormal condition.
// - Host clears the cause, then pulls fault clear low to leave alarm.
// - Any latched alarm is cleared at power-up without a clear input.
// - The operator panel clear request acts like the fault clear input.
// - Rotation output is low while speed exceeds the threshold.
// - Threshold is rpm, 0 to 3000, default 20, taking effect at once.
// - Ready is low only with servo on, prep done, no alarm, power on.
// - Index output is low while the encoder sits at its index mark.
// - Contact inputs and status outputs other than alarm are on when low, off when high.
`timescale 1ns/1ps
`include "servo_seq_io_cfg.svh"
module servo_sequence_io_logic #(
    parameter int TRQ_W = 16,
    parameter int SPD_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic fwd_limit_contact_in,
    input wire logic rev_limit_contact_in,
    input wire logic fault_clear_in,
    input wire logic panel_fault_clear,
    input wire logic [3:0] function_select_cfg,
    input wire logic [3:0] control_mode_cfg,
    input wire logic [15:0] rotation_threshold_cfg,
    input wire logic signed [TRQ_W-1:0] analog_torque_limit,
    input wire logic signed [SPD_W-1:0] motor_speed_rpm,
    input wire servo_seq_io_pkg::drive_state_t drive_state,
    output logic fault_indicator_out,
    output logic rotation_detected_out,
    output logic servo_ready_out,
    output logic index_pulse_out,
    output servo_seq_io_pkg::ctrl_mode_t active_mode,
    output logic ext_limit_active,
    output logic [TRQ_W-1:0] fwd_torque_limit,
    output logic [TRQ_W-1:0] rev_torque_limit
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [TRQ_W-1:0] mag_trq(
        input logic signed [TRQ_W-1:0] v);
        mag_trq = v[TRQ_W-1] ? TRQ_W'(-v) : TRQ_W'(v);
    endfunction

    function automatic logic [SPD_W-1:0] mag_spd(
        input logic signed [SPD_W-1:0] v);
        mag_spd = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Three stages; stage two and three must agree before a change counts.
    logic [2:0] fwd_sync;
    logic [2:0] rev_sync;
    logic [2:0] clr_sync;
    logic fwd_off;
    logic rev_off;
    logic clr_on;
    logic clr_on_d;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fwd_sync <= 3'b111;
            rev_sync <= 3'b111;
            clr_sync <= 3'b111;
        end else begin
            fwd_sync <= {fwd_sync[1:0], fwd_limit_contact_in};
            rev_sync <= {rev_sync[1:0], rev_limit_contact_in};
            clr_sync <= {clr_sync[1:0], fault_clear_in};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fwd_off <= 1'b1;
            rev_off <= 1'b1;
            clr_on <= 1'b0;
            clr_on_d <= 1'b0;
        end else begin
            if (fwd_sync[1] == fwd_sync[2]) begin
                fwd_off <= fwd_sync[2];
            end
            if (rev_sync[1] == rev_sync[2]) begin
                rev_off <= rev_sync[2];
            end
            if (clr_sync[1] == clr_sync[2]) begin
                clr_on <= ~clr_sync[2];
            end
            clr_on_d <= clr_on;
        end
    end

    // ------------------------------------------------------------------
    // Control mode selection
    // ------------------------------------------------------------------
    servo_seq_io_pkg::ctrl_mode_t base_mode;
    servo_seq_io_pkg::ctrl_mode_t alt_mode;
    servo_seq_io_pkg::ctrl_mode_t next_mode;
    logic both_off;

    always_comb begin
        base_mode = servo_seq_io_pkg::CTRL_SPEED_CONTACT;
        alt_mode = servo_seq_io_pkg::CTRL_SPEED_CONTACT;
        case (control_mode_cfg)
            `MODE_SPD_ASPD: begin
                alt_mode = servo_seq_io_pkg::CTRL_SPEED_ANALOG;
            end
            `MODE_SPD_POS: begin
                alt_mode = servo_seq_io_pkg::CTRL_POSITION;
            end
            `MODE_SPD_TRQ: begin
                alt_mode = servo_seq_io_pkg::CTRL_TORQUE;
            end
            `MODE_POS_ASPD: begin
                base_mode = servo_seq_io_pkg::CTRL_POSITION;
                alt_mode = servo_seq_io_pkg::CTRL_SPEED_ANALOG;
            end
            `MODE_POS_TRQ: begin
                base_mode = servo_seq_io_pkg::CTRL_POSITION;
                alt_mode = servo_seq_io_pkg::CTRL_TORQUE;
            end
            `MODE_TRQ_ASPD: begin
                base_mode = servo_seq_io_pkg::CTRL_TORQUE;
                alt_mode = servo_seq_io_pkg::CTRL_SPEED_ANALOG;
            end
            `MODE_ASPD_ZCLAMP: begin
                base_mode = servo_seq_io_pkg::CTRL_SPEED_ANALOG;
                alt_mode = servo_seq_io_pkg::CTRL_ZERO_CLAMP;
            end
            `MODE_POS_INHIBIT: begin
                base_mode = servo_seq_io_pkg::CTRL_POSITION;
                alt_mode = servo_seq_io_pkg::CTRL_POS_INHIBIT;
            end
            default: begin
                base_mode = servo_seq_io_pkg::CTRL_SPEED_CONTACT;
                alt_mode = servo_seq_io_pkg::CTRL_SPEED_CONTACT;
            end
        endcase
    end

    // Switching by the limit contacts is defined only for digits 4 to 6;
    // for the others the switch input is outside this block, base is held.
    assign both_off = fwd_off & rev_off;

    always_comb begin
        next_mode = base_mode;
        if ((control_mode_cfg == `MODE_SPD_ASPD ||
             control_mode_cfg == `MODE_SPD_POS ||
             control_mode_cfg == `MODE_SPD_TRQ) && both_off) begin
            next_mode = alt_mode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            active_mode <= servo_seq_io_pkg::CTRL_SPEED_CONTACT;
        end else begin
            active_mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // Analog torque limit
    // ------------------------------------------------------------------
    logic next_ext;
    logic [TRQ_W-1:0] trq_mag;

    assign trq_mag = mag_trq(analog_torque_limit);

    always_comb begin
        next_ext = (function_select_cfg == `TLIM_ANALOG_SEL) &&
                   (next_mode != servo_seq_io_pkg::CTRL_TORQUE);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ext_limit_active <= 1'b0;
            fwd_torque_limit <= '1;
            rev_torque_limit <= '1;
        end else begin
            ext_limit_active <= next_ext;
            // All ones means no limit from this path
            fwd_torque_limit <= next_ext ? trq_mag : '1;
            rev_torque_limit <= next_ext ? trq_mag : '1;
        end
    end

    // ------------------------------------------------------------------
    // Alarm latch
    // ------------------------------------------------------------------
    logic alarm_latched;
    logic clear_req;

    assign clear_req = (clr_on & ~clr_on_d) | panel_fault_clear;

    // Reset is the power-up path: the latch starts clear.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            alarm_latched <= 1'b0;
        end else if (drive_state.fault_detected) begin
            // Live fault wins over a clear in the same cycle
            alarm_latched <= 1'b1;
        end else if (clear_req) begin
            alarm_latched <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    logic [15:0] thresh;
    logic [SPD_W-1:0] spd_mag;

    assign thresh = (rotation_threshold_cfg > `ROT_THRESH_MAX) ?
                    `ROT_THRESH_MAX : rotation_threshold_cfg;
    assign spd_mag = mag_spd(motor_speed_rpm);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fault_indicator_out <= 1'b0;
            rotation_detected_out <= 1'b1;
            servo_ready_out <= 1'b1;
            index_pulse_out <= 1'b1;
        end else begin
            fault_indicator_out <= alarm_latched |
                                   drive_state.fault_detected;
            rotation_detected_out <=
                ~(32'(spd_mag) > 32'(thresh));
            servo_ready_out <= ~(drive_state.servo_on_cmd &
                                 drive_state.prep_done &
                                 drive_state.main_power_on &
                                 ~alarm_latched &
                                 ~drive_state.fault_detected);
            index_pulse_out <= ~drive_state.encoder_index;
        end
    end
endmodule

/* File: bench/servo_host_model.sv */
// Host controller model driving the low-active contact inputs.
`timescale 1ns/1ps
module servo_host_model (
    input wire logic fwd_on,
    input wire logic rev_on,
    input wire logic clr_on,
    output logic fwd_limit_contact_in,
    output logic rev_limit_contact_in,
    output logic fault_clear_in
);
    assign fwd_limit_contact_in = !fwd_on;
    assign rev_limit_contact_in = !rev_on;
    assign fault_clear_in = !clr_on;
endmodule

/* File: bench/servo_sequence_io_logic_chk.sv */
// Assertion checker for the servo sequence I/O logic.
`timescale 1ns/1ps
`include "servo_seq_io_cfg.svh"
module servo_io_chk #(
    parameter int TRQ_W = 16,
    parameter int SPD_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic fault_clear_in,
    input wire logic [3:0] function_select_cfg,
    input wire logic [15:0] rotation_threshold_cfg,
    input wire logic signed [TRQ_W-1:0] analog_torque_limit,
    input wire logic signed [SPD_W-1:0] motor_speed_rpm,
    input wire servo_seq_io_pkg::drive_state_t drive_state,
    input wire logic fault_indicator_out,
    input wire logic rotation_detected_out,
    input wire logic servo_ready_out,
    input wire logic index_pulse_out,
    input wire servo_seq_io_pkg::ctrl_mode_t active_mode,
    input wire logic ext_limit_active,
    input wire logic [TRQ_W-1:0] fwd_torque_limit,
    input wire logic [TRQ_W-1:0] rev_torque_limit
);
    logic [SPD_W-1:0] spd;
    logic [TRQ_W-1:0] lim;
    logic [15:0] thr;
    logic ok;
    logic spinning;
    assign spd = motor_speed_rpm < 0 ? -motor_speed_rpm : motor_speed_rpm;
    assign lim = analog_torque_limit < 0 ? -analog_torque_limit
        : analog_torque_limit;
    // Threshold above range is treated as the top of the range
    assign thr = rotation_threshold_cfg > `ROT_THRESH_MAX ? `ROT_THRESH_MAX
        : rotation_threshold_cfg;
    assign ok = drive_state.servo_on_cmd && drive_state.prep_done
        && drive_state.main_power_on && !drive_state.fault_detected;
    // Held in a helper so that the sampled-value call sees one signal
    assign spinning = spd > thr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence clr_req;
        $fell(fault_clear_in) && !drive_state.fault_detected;
    endsequence
    sequence cause_gone;
        !drive_state.fault_detected [*7];
    endsequence
    chk_ready_gate: assert property (
        !servo_ready_out |-> $past(ok)) else $error("ready without cause");
    chk_ready_alarm: assert property (
        fault_indicator_out |-> servo_ready_out)
        else $error("ready during alarm");
    chk_index_follow: assert property (
        $past(rst_b) |-> index_pulse_out == !$past(drive_state.encoder_index))
        else $error("index output wrong");
    chk_fault_set: assert property (
        $past(rst_b) && $past(drive_state.fault_detected)
        |-> fault_indicator_out) else $error("alarm not raised");
    chk_fault_clear: assert property (
        clr_req ##1 cause_gone |-> !fault_indicator_out)
        else $error("alarm not cleared");
    chk_rot_detect: assert property (
        $past(rst_b) |-> rotation_detected_out == !$past(spinning))
        else $error("rotation output wrong");
    chk_limit_pair: assert property (
        fwd_torque_limit == rev_torque_limit) else $error("limits differ");
    chk_trq_ignore: assert property (
        active_mode == servo_seq_io_pkg::CTRL_TORQUE |-> !ext_limit_active)
        else $error("limit used in torque mode");
    chk_ext_gate: assert property (
        ext_limit_active && $stable(function_select_cfg)
        |-> function_select_cfg == `TLIM_ANALOG_SEL) else $error("ext gate");
    chk_limit_value: assert property (
        $stable(analog_torque_limit)
        |-> fwd_torque_limit == (ext_limit_active ? lim : '1))
        else $error("limit value wrong");
endmodule
bind servo_sequence_io_logic servo_io_chk #(.TRQ_W(TRQ_W), .SPD_W(SPD_W))
    servo_io_chk_inst (.clk_sys, .rst_b, .fault_clear_in,
    .function_select_cfg, .rotation_threshold_cfg, .analog_torque_limit,
    .motor_speed_rpm, .drive_state, .fault_indicator_out,
    .rotation_detected_out, .servo_ready_out, .index_pulse_out,
    .active_mode, .ext_limit_active, .fwd_torque_limit, .rev_torque_limit);

/* File: bench/tb_servo_sequence_io_logic.sv */
// Self-checking testbench for the servo sequence I/O logic.
`timescale 1ns/1ps
`include "servo_seq_io_cfg.svh"
module tb_servo_sequence_io_logic;
    localparam logic [2:0] SC = servo_seq_io_pkg::CTRL_SPEED_CONTACT;
    localparam logic [2:0] SA = servo_seq_io_pkg::CTRL_SPEED_ANALOG;
    localparam logic [2:0] PO = servo_seq_io_pkg::CTRL_POSITION;
    localparam logic [2:0] TQ = servo_seq_io_pkg::CTRL_TORQUE;
    localparam logic [2:0] ZC = servo_seq_io_pkg::CTRL_ZERO_CLAMP;
    localparam logic [2:0] PI = servo_seq_io_pkg::CTRL_POS_INHIBIT;
    logic [2:0] base_m [4:11] = '{SC, SC, SC, PO, PO, TQ, SA, PO};
    logic [2:0] alt_m [4:11] = '{SA, PO, TQ, SA, TQ, SA, ZC, PI};
    logic [15:0] tv [6] = '{16'h0014, 16'h0014, 16'h0014, 16'h1388,
        16'h1388, 16'h0000};
    logic [15:0] sv [6] = '{16'h0015, 16'h0014, 16'hFFEB, 16'h0BB9,
        16'h0BB8, 16'h0001};
    logic [5:0] ev = 6'h12;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic fwd_on = 1'b0;
    logic rev_on = 1'b0;
    logic clr_on = 1'b0;
    logic pclr = 1'b0;
    logic [3:0] fsel = `TLIM_ANALOG_SEL;
    logic [3:0] mode = 4'h4;
    logic [15:0] thr = `ROT_THRESH_DEFAULT;
    logic signed [15:0] atl = 16'h0000;
    logic signed [15:0] spd = 16'h0000;
    servo_seq_io_pkg::drive_state_t ds = '0;
    servo_seq_io_pkg::ctrl_mode_t am;
    logic fc, rc, cc, flt, rot, rdy, idx, ext;
    logic [15:0] fl, rl;
    logic [2:0] em;
    logic [15:0] fexp;
    int n_mismatch = 0;
    int num_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    servo_host_model servo_host_model_inst (.fwd_on, .rev_on, .clr_on,
        .fwd_limit_contact_in(fc), .rev_limit_contact_in(rc),
        .fault_clear_in(cc));
    servo_sequence_io_logic servo_sequence_io_logic_inst (.clk_sys, .rst_b,
        .fwd_limit_contact_in(fc), .rev_limit_contact_in(rc),
        .fault_clear_in(cc), .panel_fault_clear(pclr),
        .function_select_cfg(fsel), .control_mode_cfg(mode),
        .rotation_threshold_cfg(thr), .analog_torque_limit(atl),
        .motor_speed_rpm(spd), .drive_state(ds), .fault_indicator_out(flt),
        .rotation_detected_out(rot), .servo_ready_out(rdy),
        .index_pulse_out(idx), .active_mode(am), .ext_limit_active(ext),
        .fwd_torque_limit(fl), .rev_torque_limit(rl));
    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Host must remove the cause before asking for a clear
    task automatic fault_pulse();
        ds.fault_detected = 1'b1;
        cyc(1);
        ds.fault_detected = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #(25 * 3000);
        n_mismatch++;
        final_report();
    end
    initial begin
        cyc(2);
        check("reset", {flt, rot, rdy, idx, ext, am}, 16'h0070);
        check("lim_rst", fl, 16'hFFFF);
        rst_b = 1'b1;
        ds = 5'h0E;
        cyc(2);
        check("ready", 16'(rdy), 16'h0000);
        ds.main_power_on = 1'b0;
        cyc(2);
        check("rdy_pwr", 16'(rdy), 16'h0001);
        ds.main_power_on = 1'b1;
        ds.encoder_index = 1'b1;
        cyc(1);
        check("index", 16'(idx), 16'h0000);
        ds.encoder_index = 1'b0;
        cyc(1);
        check("index_off", 16'(idx), 16'h0001);
        $display("status test done");
        for (int i = 0; i < 6; i++) begin
            thr = tv[i];
            spd = sv[i];
            cyc(2);
            check("rotation", 16'(rot), 16'(ev[i]));
        end
        $display("rotation test done");
        for (int d = 4; d < 12; d++) begin
            mode = 4'(d);
            atl = d[0] ? 16'h012C : 16'hFED4;
            for (int c = 0; c < 3; c++) begin
                fwd_on = (c == 0);
                rev_on = (c == 1);
                cyc(8);
                em = (c == 2 && d < 7) ? alt_m[d] : base_m[d];
                fexp = (em != TQ) ? 16'h012C : 16'hFFFF;
                check("mode", 16'(am), 16'(em));
                check("ext", 16'(ext), 16'(em != TQ));
                check("fwd", fl, fexp);
                check("rev", rl, fexp);
            end
        end
        fsel = 4'h0;
        cyc(8);
        check("ext_off", 16'(ext), 16'h0000);
        check("lim_off", fl, 16'hFFFF);
        mode = 4'h0;
        cyc(8);
        check("mode_def", 16'(am), 16'(SC));
        $display("mode test done");
        fault_pulse();
        check("alarm", {flt, rdy}, 16'h0003);
        cyc(5);
        check("latched", 16'(flt), 16'h0001);
        clr_on = 1'b1;
        cyc(10);
        check("cleared", 16'(flt), 16'h0000);
        fault_pulse();
        cyc(10);
        check("held_clr", 16'(flt), 16'h0001);
        clr_on = 1'b0;
        pclr = 1'b1;
        cyc(1);
        pclr = 1'b0;
        cyc(2);
        check("panel", 16'(flt), 16'h0000);
        fault_pulse();
        cyc(3);
        check("pre_rst", 16'(flt), 16'h0001);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(1);
        check("powerup", 16'(flt), 16'h0000);
        $display("alarm test done");
        final_report();
    end
endmodule
